// [hdl/pmpc_pkg.sv]
// Package with offsets, field positions and reset values of the power and PHY control registers.
package pmpc_pkg;
    localparam logic [7:0] OFF_PM_CSR = 8'h48;
    localparam logic [7:0] OFF_PM_EXT = 8'h4a;
    localparam logic [7:0] OFF_PHY_CTRL = 8'hec;
    localparam logic [7:0] OFF_MISC_CFG = 8'hf0;
    localparam int BIT_WAKE_STS = 15;
    localparam int BIT_WAKE_EN = 8;
    localparam int BIT_COLD_WAKE = 15;
    localparam int BIT_LINK_ROUTE = 7;
    localparam int BIT_PHY_RST = 4;
    localparam int BIT_COMPLY = 3;
    localparam int BIT_PHY_PD = 2;
    localparam logic [15:0] PM_EXT_VALUE = 16'h0000;
    localparam logic [7:0] PHY_CTRL_RESET = 8'h08;
    localparam logic [1:0] POWER_STATE_FIELD_RESET = 2'h0;
    localparam logic [1:0] PWR_D3 = 2'h3;
    typedef enum logic [1:0] {
        PMPC_D0 = 2'b00,
        PMPC_D1 = 2'b01,
        PMPC_D2 = 2'b10,
        PMPC_D3 = 2'b11
    } pmpc_pwr_t;
endpackage : pmpc_pkg

// [hdl/pmpc_regs.sv]
// Power-management control/status, extension and PHY control configuration registers.
// Behaviour
// - D3hot-to-D0 internal reset leaves CSR intact.
// - Wake event sets status regardless of enable.
// - Writing one clears status and wake output.
// - Data scale field reads zero.
// - Data select field reads zero.
// - Wake output asserts only while enabled.
// - Wake enable resets unless cold wake capable; global reset here clears it whatever the cold wake bit holds.
// - CSR bits 7-2 read zero.
// - Power state field is read/write.
// - Only global reset clears marked bits.
// - Extension register reads zero, read-only.
// - PHY control bits 31-8 read zero.
// - Bit 7 routes link-on output out.
// - PHY control bits 6-5 read zero.
// - Bit 4 drives PHY reset directly.
// - Bit 3 resets to one, EEPROM loadable.
// - Bit 2 drives PHY power-down.
// - Bits 1-0 EEPROM loaded, read back as stored.
// - Misc bit 15 programs cold wake capability.
`timescale 1ns/10ps
module pmpc_regs (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_func_rst_n,
    input wire logic i_cfg_wr,
    input wire logic i_cfg_rd,
    input wire logic [7:0] i_cfg_addr,
    input wire logic [3:0] i_cfg_be,
    input wire logic [31:0] i_cfg_wdata,
    input wire logic i_wake_event,
    input wire logic i_phy_link_on_output,
    input wire logic i_eeprom_load,
    input wire logic [7:0] i_eeprom_phy_bits,
    output logic [31:0] o_cfg_rdata,
    output logic o_cfg_ack,
    output logic o_wake_n,
    output logic o_phy_link_on_output,
    output logic o_phy_reset_control,
    output logic o_phy_power_down,
    output logic [1:0] o_power_state_field,
    output logic o_cold_state_wake_capable
);
    // Link-on input comes from the PHY; it passes two synchronizer flip-flops, then the output register.
    logic link_s1_reg;
    logic link_s1_next;
    logic link_s2_reg;
    logic link_s2_next;
    // Power-management control/status storage.
    logic sts_reg;
    logic sts_next;
    logic en_reg;
    logic en_next;
    logic cold_reg;
    logic cold_next;
    pmpc_pkg::pmpc_pwr_t pwr_reg;
    pmpc_pkg::pmpc_pwr_t pwr_next;
    // PHY control storage.
    logic link_route_reg;
    logic link_route_next;
    logic phy_rst_reg;
    logic phy_rst_next;
    logic comply_reg;
    logic comply_next;
    logic pd_reg;
    logic pd_next;
    logic [1:0] eep_reg;
    logic [1:0] eep_next;
    // Registered bus answer and pin drivers.
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic ack_reg;
    logic ack_next;
    logic wake_n_reg;
    logic wake_n_next;
    logic link_out_reg;
    logic link_out_next;
    // Write strobes decoded per dword.
    logic wr_csr;
    logic wr_phy;
    logic wr_misc;

    // True when a byte address falls in the dword of the given register offset.
    function automatic logic dword_hit(input logic [7:0] addr, input logic [7:0] off);
        return addr[7:2] == off[7:2];
    endfunction : dword_hit

    // Returns the 32-bit dword image seen at a config address.
    function automatic logic [31:0] read_word(input logic [7:0] addr, input logic sts,
        input logic en, input logic [1:0] pwr, input logic [7:0] phy, input logic cold);
        logic [31:0] w;
        w = 32'h0000_0000;
        if (dword_hit(addr, pmpc_pkg::OFF_PM_CSR)) begin
            // Upper half is the extension register, fixed at zero.
            w[31:16] = pmpc_pkg::PM_EXT_VALUE;
            w[pmpc_pkg::BIT_WAKE_STS] = sts;
            w[pmpc_pkg::BIT_WAKE_EN] = en;
            w[1:0] = pwr;
        end else if (dword_hit(addr, pmpc_pkg::OFF_PHY_CTRL)) begin
            w[7:0] = phy;
        end else if (dword_hit(addr, pmpc_pkg::OFF_MISC_CFG)) begin
            w[pmpc_pkg::BIT_COLD_WAKE] = cold;
        end
        return w;
    endfunction : read_word

    // Write strobes; the extension half of 48h has no storage, so writes vanish.
    always_comb begin
        wr_csr = i_cfg_wr && dword_hit(i_cfg_addr, pmpc_pkg::OFF_PM_CSR);
        wr_phy = i_cfg_wr && dword_hit(i_cfg_addr, pmpc_pkg::OFF_PHY_CTRL);
        wr_misc = i_cfg_wr && dword_hit(i_cfg_addr, pmpc_pkg::OFF_MISC_CFG);
    end

    // Next state of the synchronizer and control registers; the function reset never touches them.
    always_comb begin
        link_s1_next = i_phy_link_on_output;
        link_s2_next = link_s1_reg;
        sts_next = sts_reg;
        en_next = en_reg;
        pwr_next = pwr_reg;
        cold_next = cold_reg;
        link_route_next = link_route_reg;
        phy_rst_next = phy_rst_reg;
        comply_next = comply_reg;
        pd_next = pd_reg;
        eep_next = eep_reg;
        // i_func_rst_n models the D3hot-to-D0 reset and is deliberately unused here.
        if (wr_csr && i_cfg_be[1] && i_cfg_wdata[pmpc_pkg::BIT_WAKE_STS]) begin
            sts_next = 1'b0;
        end
        // A wake event is applied last, so it wins over a clear in the same cycle.
        if (i_wake_event) begin
            sts_next = 1'b1;
        end
        // Byte lane 1 carries the wake enable.
        if (wr_csr && i_cfg_be[1]) begin
            en_next = i_cfg_wdata[pmpc_pkg::BIT_WAKE_EN];
        end
        // Byte lane 0 carries the power-state field.
        if (wr_csr && i_cfg_be[0]) begin
            pwr_next = pmpc_pkg::pmpc_pwr_t'(i_cfg_wdata[1:0]);
        end
        // Only the cold-wake capability bit of the misc register is stored.
        if (wr_misc && i_cfg_be[1]) begin
            cold_next = i_cfg_wdata[pmpc_pkg::BIT_COLD_WAKE];
        end
        // The PHY control byte; reserved bits 6-5 have no storage at all.
        if (wr_phy && i_cfg_be[0]) begin
            link_route_next = i_cfg_wdata[pmpc_pkg::BIT_LINK_ROUTE];
            phy_rst_next = i_cfg_wdata[pmpc_pkg::BIT_PHY_RST];
            comply_next = i_cfg_wdata[pmpc_pkg::BIT_COMPLY];
            pd_next = i_cfg_wdata[pmpc_pkg::BIT_PHY_PD];
            eep_next = i_cfg_wdata[1:0];
        end
        // EEPROM preload wins over a simultaneous config write.
        if (i_eeprom_load) begin
            link_route_next = i_eeprom_phy_bits[pmpc_pkg::BIT_LINK_ROUTE];
            comply_next = i_eeprom_phy_bits[pmpc_pkg::BIT_COMPLY];
            eep_next = i_eeprom_phy_bits[1:0];
        end
    end

    // Read data, wake pin and link-on routing, all registered.
    always_comb begin
        rdata_next = rdata_reg;
        ack_next = i_cfg_rd || i_cfg_wr;
        if (i_cfg_rd) begin
            rdata_next = read_word(i_cfg_addr, sts_reg, en_reg, pwr_reg,
                {link_route_reg, 2'b00, phy_rst_reg, comply_reg, pd_reg, eep_reg},
                cold_reg);
        end
        wake_n_next = !(sts_next && en_next);
        link_out_next = link_route_reg && link_s2_reg;
    end

    // Registers; only the global reset clears them.
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            link_s1_reg <= 1'b0;
            link_s2_reg <= 1'b0;
            sts_reg <= 1'b0;
            // Cold-wake capability clears too, so wake enable defaults to zero.
            en_reg <= 1'b0;
            cold_reg <= 1'b0;
            pwr_reg <= pmpc_pkg::PMPC_D0;
            link_route_reg <= pmpc_pkg::PHY_CTRL_RESET[pmpc_pkg::BIT_LINK_ROUTE];
            phy_rst_reg <= pmpc_pkg::PHY_CTRL_RESET[pmpc_pkg::BIT_PHY_RST];
            comply_reg <= pmpc_pkg::PHY_CTRL_RESET[pmpc_pkg::BIT_COMPLY];
            pd_reg <= pmpc_pkg::PHY_CTRL_RESET[pmpc_pkg::BIT_PHY_PD];
            eep_reg <= pmpc_pkg::PHY_CTRL_RESET[1:0];
            rdata_reg <= 32'h0000_0000;
            ack_reg <= 1'b0;
            wake_n_reg <= 1'b1;
            link_out_reg <= 1'b0;
        end else begin
            link_s1_reg <= link_s1_next;
            link_s2_reg <= link_s2_next;
            sts_reg <= sts_next;
            en_reg <= en_next;
            cold_reg <= cold_next;
            pwr_reg <= pwr_next;
            link_route_reg <= link_route_next;
            phy_rst_reg <= phy_rst_next;
            comply_reg <= comply_next;
            pd_reg <= pd_next;
            eep_reg <= eep_next;
            rdata_reg <= rdata_next;
            ack_reg <= ack_next;
            wake_n_reg <= wake_n_next;
            link_out_reg <= link_out_next;
        end
    end

    assign o_cfg_rdata = rdata_reg;
    assign o_cfg_ack = ack_reg;
    assign o_wake_n = wake_n_reg;
    assign o_phy_link_on_output = link_out_reg;
    assign o_phy_reset_control = phy_rst_reg;
    assign o_phy_power_down = pd_reg;
    assign o_power_state_field = pwr_reg;
    assign o_cold_state_wake_capable = cold_reg;

    // Checks on the register behaviour.
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);

    // Wake status, enable, the wake pin, function reset and power state writes.
    a_sts_sets: assert property (i_wake_event |=> sts_reg)
        else $error("wake status did not set");
    a_sts_clears: assert property (
        wr_csr && i_cfg_be[1] && i_cfg_wdata[pmpc_pkg::BIT_WAKE_STS] && !i_wake_event
        |=> !sts_reg && o_wake_n)
        else $error("wake status clear failed");
    a_sts_holds: assert property (
        !i_wake_event && !(wr_csr && i_cfg_be[1] && i_cfg_wdata[pmpc_pkg::BIT_WAKE_STS])
        |=> $stable(sts_reg))
        else $error("wake status changed without cause");
    a_wake_gated: assert property (!en_reg |-> o_wake_n)
        else $error("wake asserted while disabled");
    a_wake_drives: assert property (sts_reg && en_reg |-> !o_wake_n)
        else $error("wake not asserted");
    a_en_write: assert property (wr_csr && i_cfg_be[1]
        |=> en_reg == $past(i_cfg_wdata[pmpc_pkg::BIT_WAKE_EN]))
        else $error("wake enable not written");
    a_func_rst: assert property (!i_func_rst_n && !i_cfg_wr && !i_wake_event
        |=> $stable(sts_reg) && $stable(en_reg) && $stable(pwr_reg))
        else $error("function reset changed CSR");
    a_pwr_write: assert property (wr_csr && i_cfg_be[0]
        |=> o_power_state_field == $past(i_cfg_wdata[1:0]))
        else $error("power state not written");

    // Fixed fields as they are read back.
    a_csr_zeros: assert property (
        i_cfg_rd && dword_hit(i_cfg_addr, pmpc_pkg::OFF_PM_CSR)
        |=> o_cfg_rdata[31:16] == 16'h0000 && o_cfg_rdata[14:9] == 6'h00
        && o_cfg_rdata[7:2] == 6'h00)
        else $error("fixed CSR fields nonzero");
    a_phy_zeros: assert property (
        i_cfg_rd && dword_hit(i_cfg_addr, pmpc_pkg::OFF_PHY_CTRL)
        |=> o_cfg_rdata[31:8] == 24'h00_0000 && o_cfg_rdata[6:5] == 2'b00)
        else $error("PHY control reserved bits nonzero");
    a_misc_zeros: assert property (
        i_cfg_rd && dword_hit(i_cfg_addr, pmpc_pkg::OFF_MISC_CFG)
        |=> o_cfg_rdata[31:16] == 16'h0000 && o_cfg_rdata[14:0] == 15'h0000)
        else $error("misc config unused bits nonzero");

    // PHY control outputs, preload, link-on routing and the cold wake bit.
    a_phy_rst: assert property (wr_phy && i_cfg_be[0]
        |=> o_phy_reset_control == $past(i_cfg_wdata[pmpc_pkg::BIT_PHY_RST]))
        else $error("PHY reset not following bit 4");
    a_pd_follows: assert property (wr_phy && i_cfg_be[0]
        |=> o_phy_power_down == $past(i_cfg_wdata[pmpc_pkg::BIT_PHY_PD]))
        else $error("PHY power-down not following bit 2");
    a_eeprom_load: assert property (i_eeprom_load
        |=> link_route_reg == $past(i_eeprom_phy_bits[pmpc_pkg::BIT_LINK_ROUTE])
        && comply_reg == $past(i_eeprom_phy_bits[pmpc_pkg::BIT_COMPLY]))
        else $error("EEPROM preload not taken");
    a_eep_bits: assert property (i_eeprom_load
        |=> eep_reg == $past(i_eeprom_phy_bits[1:0]))
        else $error("EEPROM low bits not taken");
    a_route_gate: assert property (!link_route_reg |=> !o_phy_link_on_output)
        else $error("link-on passed while not routed");
    a_route_pass: assert property (link_route_reg && link_s2_reg
        |=> o_phy_link_on_output)
        else $error("link-on not routed");
    a_cold_write: assert property (wr_misc && i_cfg_be[1]
        |=> o_cold_state_wake_capable == $past(i_cfg_wdata[pmpc_pkg::BIT_COLD_WAKE]))
        else $error("cold wake capability not written");

    // Bus answer timing.
    a_ack_follows: assert property (i_cfg_rd || i_cfg_wr |=> o_cfg_ack)
        else $error("access not acknowledged");
    a_ack_idle: assert property (!i_cfg_rd && !i_cfg_wr |=> !o_cfg_ack)
        else $error("acknowledge without access");
    a_rdata_holds: assert property (!i_cfg_rd |=> $stable(o_cfg_rdata))
        else $error("read data moved without a read");

    c_wake: cover property (i_wake_event ##1 !o_wake_n);
    c_clear: cover property (!o_wake_n ##1 wr_csr ##2 o_wake_n);
    c_d3: cover property (o_power_state_field == pmpc_pkg::PWR_D3);
    c_pd: cover property (o_phy_power_down ##[1:20] !o_phy_power_down);
    c_preload: cover property (i_eeprom_load ##1 comply_reg);
endmodule : pmpc_regs

// [test/pmpc_phy_model.sv]
// Behavioural model of the PHY that feeds the link-on level.
`timescale 1ns/10ps
module pmpc_phy_model (
    input wire logic i_ref_clk,
    input wire logic i_phy_reset,
    input wire logic i_phy_power_down,
    input wire logic i_link_req,
    output logic o_link_on
);
    // A PHY held in reset or powered down never raises link-on.
    always_ff @(posedge i_ref_clk) begin
        o_link_on <= i_link_req & ~i_phy_reset & ~i_phy_power_down;
    end
endmodule : pmpc_phy_model

// [test/tb_top.sv]
// Self-checking testbench for the power and PHY control registers.
`timescale 1ns/10ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin fail_count++; \
    $display("mismatch at %0t: got %h expected %h", $time, a, b); end end
module tb_top;
    logic i_ref_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic i_func_rst_n = 1'b1;
    logic i_cfg_wr = 1'b0;
    logic i_cfg_rd = 1'b0;
    logic [7:0] i_cfg_addr = 8'h00;
    logic [3:0] i_cfg_be = 4'h0;
    logic [31:0] i_cfg_wdata = 32'h0000_0000;
    logic i_wake_event = 1'b0;
    logic i_eeprom_load = 1'b0;
    logic [7:0] i_eeprom_phy_bits = 8'h00;
    logic link_req = 1'b0;
    logic link_on, o_cfg_ack, o_wake_n, o_link, o_phy_rst, o_phy_pd, o_cold;
    logic [31:0] o_cfg_rdata;
    logic [1:0] o_pwr;
    int fail_count = 0;
    int check_count = 0;
    // Clock of 40 ns period.
    always #20 i_ref_clk = ~i_ref_clk;
    pmpc_regs u_pmpc_regs (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_func_rst_n(i_func_rst_n),
        .i_cfg_wr(i_cfg_wr), .i_cfg_rd(i_cfg_rd), .i_cfg_addr(i_cfg_addr), .i_cfg_be(i_cfg_be),
        .i_cfg_wdata(i_cfg_wdata), .i_wake_event(i_wake_event), .i_phy_link_on_output(link_on),
        .i_eeprom_load(i_eeprom_load), .i_eeprom_phy_bits(i_eeprom_phy_bits),
        .o_cfg_rdata(o_cfg_rdata), .o_cfg_ack(o_cfg_ack), .o_wake_n(o_wake_n),
        .o_phy_link_on_output(o_link), .o_phy_reset_control(o_phy_rst),
        .o_phy_power_down(o_phy_pd), .o_power_state_field(o_pwr),
        .o_cold_state_wake_capable(o_cold));
    pmpc_phy_model u_pmpc_phy_model (.i_ref_clk(i_ref_clk), .i_phy_reset(o_phy_rst),
        .i_phy_power_down(o_phy_pd), .i_link_req(link_req), .o_link_on(link_on));
    task automatic tally_and_finish;
        if (fail_count == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : tally_and_finish
    task automatic tick(input int n);
        repeat (n) @(posedge i_ref_clk);
        #1;
    endtask : tick
    // One config access, then one idle cycle so strobes never toggle twice at one edge.
    task automatic access(input logic wr, input logic [7:0] a, input logic [3:0] be,
                          input logic [31:0] d);
        i_cfg_wr = wr;
        i_cfg_rd = !wr;
        i_cfg_addr = a;
        i_cfg_be = be;
        i_cfg_wdata = d;
        tick(1);
        `CHK(o_cfg_ack, 1'b1)
        i_cfg_wr = 1'b0;
        i_cfg_rd = 1'b0;
        tick(1);
    endtask : access
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        access(1'b0, a, 4'hf, 32'h0000_0000);
        `CHK(o_cfg_rdata, exp)
    endtask : rd_chk
    task automatic do_reset;
        i_rst_n = 1'b0;
        tick(6);
        i_rst_n = 1'b1;
    endtask : do_reset
    task automatic pulse_wake(input logic exp_n);
        i_wake_event = 1'b1;
        tick(1);
        i_wake_event = 1'b0;
        `CHK(o_wake_n, exp_n)
    endtask : pulse_wake
    task automatic wait_link(input logic v);
        int n;
        n = 0;
        while (o_link !== v && n < 8) begin
            tick(1);
            n++;
        end
        `CHK(o_link, v)
        if (o_link !== v) tally_and_finish();
    endtask : wait_link
    task automatic t_reset_vals;
        rd_chk(8'h48, 32'h0000_0000);
        rd_chk(8'hec, 32'h0000_0008);
        `CHK({o_wake_n, o_phy_rst, o_phy_pd, o_pwr, o_link, o_cold}, 7'h40)
    endtask : t_reset_vals
    // Every power state, with ones thrown at the read-only fields.
    task automatic t_csr;
        for (int s = 0; s < 4; s++) begin
            access(1'b1, 8'h48, 4'hf, 32'hffff_7efc | s);
            rd_chk(8'h48, {30'h0000_0000, s[1:0]});
            `CHK(o_pwr, s[1:0])
        end
    endtask : t_csr
    task automatic t_wake;
        access(1'b1, 8'h48, 4'h3, 32'h0000_8000);
        pulse_wake(1'b1);
        rd_chk(8'h48, 32'h0000_8000);
        access(1'b1, 8'h48, 4'h3, 32'h0000_0100);
        rd_chk(8'h48, 32'h0000_8100);
        access(1'b1, 8'h48, 4'h3, 32'h0000_8100);
        `CHK(o_wake_n, 1'b1)
        rd_chk(8'h48, 32'h0000_0100);
        pulse_wake(1'b0);
        i_func_rst_n = 1'b0;
        tick(3);
        i_func_rst_n = 1'b1;
        rd_chk(8'h48, 32'h0000_8100);
        `CHK(o_wake_n, 1'b0)
        access(1'b1, 8'h48, 4'h3, 32'h0000_8100);
        `CHK(o_wake_n, 1'b1)
        // A wake event in the cycle of a clear leaves the status set.
        i_wake_event = 1'b1;
        i_cfg_wr = 1'b1;
        i_cfg_addr = 8'h48;
        i_cfg_be = 4'h3;
        i_cfg_wdata = 32'h0000_8100;
        tick(1);
        i_wake_event = 1'b0;
        i_cfg_wr = 1'b0;
        tick(1);
        `CHK(o_wake_n, 1'b0)
    endtask : t_wake
    // PHY control outputs, the power-down then reset sequence, and link routing.
    task automatic t_phy;
        link_req = 1'b1;
        access(1'b1, 8'hec, 4'hf, 32'hffff_ff94);
        rd_chk(8'hec, 32'h0000_0094);
        `CHK({o_phy_rst, o_phy_pd}, 2'b11)
        access(1'b1, 8'hec, 4'h1, 32'h0000_0090);
        `CHK({o_phy_rst, o_phy_pd}, 2'b10)
        access(1'b1, 8'hec, 4'h1, 32'h0000_0080);
        wait_link(1'b1);
        access(1'b1, 8'hec, 4'h1, 32'h0000_0000);
        wait_link(1'b0);
        i_eeprom_phy_bits = 8'hff;
        i_eeprom_load = 1'b1;
        tick(1);
        i_eeprom_load = 1'b0;
        rd_chk(8'hec, 32'h0000_008b);
        rd_chk(8'h10, 32'h0000_0000);
        access(1'b1, 8'hf0, 4'hf, 32'hffff_ffff);
        rd_chk(8'hf0, 32'h0000_8000);
        `CHK(o_cold, 1'b1)
    endtask : t_phy
    initial begin
        do_reset();
        t_reset_vals();
        t_csr();
        t_wake();
        t_phy();
        do_reset();
        t_reset_vals();
        tally_and_finish();
    end
endmodule : tb_top
